// ===== verilog/serial_port_pkg.sv
// constants and types shared by the serial port design files
// ============================================================
// Behaviour
// RQ1: buffer write loads transmit register; buffer read returns the receive buffer.
// RQ2: shift mode: device always makes the shift clock; half duplex only.
// RQ3: asynchronous mode: transmitter and receiver run at the same time.
// RQ4: shift mode: data both ways on data pin, shift clock on clock pin.
// RQ5: shift frame is eight bits, least significant bit first.
// RQ6: shift bit rate is clock/12 with rate select 0, clock/4 with 1.
// RQ7: buffer write starts shift transmit; clock runs until eight bits are out.
// RQ8: rate select 1: data 1 clock before clock falls; low 2 clocks.
// RQ9: rate select 0: data 3 clocks before clock falls; low 6 clocks.
// RQ10: far device captures shift data on rising edge of the shift clock.
// RQ11: receiver splits each bit time into 16 slices with a counter.
// RQ12: receiver samples slices 8, 9 and 10 and takes a 2-of-3 vote; code samples slices 7, 8 and 9 (counted from 0).
// RQ13: start bit voted not 0 aborts reception; hunt for falling edge again.
// RQ14: after eight data bits one more shift, then load and set flag; code takes the stop bit vote without shifting shift_q.
// RQ15: load only if done flag clear and rate select 0 or stop bit 1.
// RQ16: on load: stop bit to capture, data to buffer, done flag set.
// RQ17: after middle of stop bit, watch again for a high-to-low edge.
// RQ18: async frame: low start, eight data bits LSB first, high stop.
package serial_port_pkg;

    // ============================================================
    // register map
    localparam logic [2:0] ADDR_BUFFER     = 3'h0;
    localparam logic [2:0] ADDR_CONTROL    = 3'h1;
    localparam logic [2:0] ADDR_STATUS     = 3'h2;
    localparam logic [2:0] ADDR_IRQ_CLEAR  = 3'h3;
    localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h4;
    localparam logic [2:0] ADDR_BAUD_DIV   = 3'h5;

    // serial_control fields
    localparam int CTL_ASYNC    = 0;
    localparam int CTL_RATE_SEL = 1;
    localparam int CTL_RX_EN    = 2;
    localparam int CTL_STOP_CAP = 3;
    localparam int CTL_TX_DONE  = 4;
    localparam int CTL_RX_DONE  = 5;

    // event bits of status, clear and enable registers
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_DONE = 1;
    localparam int EV_RX_LOST = 2;
    localparam int NUM_EV     = 3;

    // values after reset
    localparam logic [7:0]        BUFFER_RESET   = 8'h00;
    localparam logic [7:0]        BAUD_DIV_RESET = 8'h0A;
    localparam logic [NUM_EV-1:0] EV_RESET       = 3'h0;

    // shift-mode bit timing in clock cycles
    localparam logic [3:0] SHIFT_PERIOD_SLOW = 4'hC;
    localparam logic [3:0] SHIFT_PERIOD_FAST = 4'h4;
    localparam logic [3:0] SHIFT_LEAD_SLOW   = 4'h3;
    localparam logic [3:0] SHIFT_LEAD_FAST   = 4'h1;
    localparam logic [3:0] SHIFT_LOW_SLOW    = 4'h6;
    localparam logic [3:0] SHIFT_LOW_FAST    = 4'h2;
    localparam logic [2:0] SHIFT_LAST_BIT    = 3'h7;

    // asynchronous oversampling; slices counted from 0
    localparam logic [3:0] SLICE_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_A   = 4'h7;
    localparam logic [3:0] SAMPLE_B   = 4'h8;
    localparam logic [3:0] SAMPLE_C   = 4'h9;
    localparam logic [3:0] BIT_START  = 4'h0;
    localparam logic [3:0] BIT_STOP   = 4'h9;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_TX   = 3'b010,
        SH_RX   = 3'b100
    } shift_state_e;

    typedef enum logic [1:0] {
        AT_IDLE = 2'b01,
        AT_RUN  = 2'b10
    } async_tx_state_e;

    typedef enum logic [1:0] {
        AR_HUNT = 2'b01,
        AR_BITS = 2'b10
    } async_rx_state_e;

endpackage

// ===== verilog/rx_link_if.sv
// link between the port core and its asynchronous receiver
`timescale 1ns/1ns
interface rx_link_if;
    logic       tick16;
    logic       rxd;
    logic       enable;
    logic       frame_done;
    logic [7:0] data;
    logic       stop_bit;

    modport receiver (
        input  tick16,
        input  rxd,
        input  enable,
        output frame_done,
        output data,
        output stop_bit
    );

    modport core (
        output tick16,
        output rxd,
        output enable,
        input  frame_done,
        input  data,
        input  stop_bit
    );
endinterface

// ===== verilog/async_receiver.sv
// oversampling asynchronous receiver with three-sample vote
`timescale 1ns/1ns
module async_receiver
    import serial_port_pkg::*;
(
    input wire logic   clk,
    input wire logic   sys_rst,
    rx_link_if.receiver link
);

    async_rx_state_e state_q;
    logic [3:0]      slice_q;
    logic [3:0]      bit_q;
    logic [1:0]      votes_q;
    logic [7:0]      shift_q;
    logic            prev_q;
    logic            fall;
    logic            vote;

    // link.rxd is already the second synchroniser stage
    assign fall = prev_q & ~link.rxd;
    assign vote = (votes_q[0] & votes_q[1]) | (votes_q[0] & link.rxd)
                | (votes_q[1] & link.rxd); // RQ12

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= link.rxd;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q         <= AR_HUNT;
            slice_q         <= 4'h0;
            bit_q           <= 4'h0;
            votes_q         <= 2'h0;
            shift_q         <= 8'h00;
            link.frame_done <= 1'b0;
            link.data       <= 8'h00;
            link.stop_bit   <= 1'b0;
        end else begin
            link.frame_done <= 1'b0;
            case (state_q)
                AR_HUNT: begin
                    if (link.enable && fall) begin
                        state_q <= AR_BITS;
                        slice_q <= 4'h0;
                        bit_q   <= BIT_START;
                    end
                end
                AR_BITS: begin
                    if (!link.enable) begin
                        state_q <= AR_HUNT;
                    end else if (link.tick16) begin
                        slice_q <= slice_q + 4'h1; // RQ11
                        if (slice_q == SAMPLE_A) begin
                            votes_q[0] <= link.rxd;
                        end
                        if (slice_q == SAMPLE_B) begin
                            votes_q[1] <= link.rxd;
                        end
                        if (slice_q == SAMPLE_C) begin
                            if (bit_q == BIT_START) begin
                                if (vote) begin
                                    state_q <= AR_HUNT; // RQ13
                                end
                            end else if (bit_q == BIT_STOP) begin
                                // stop bit vote goes straight to stop_bit; shift_q is not shifted
                                link.frame_done <= 1'b1; // RQ14
                                link.data       <= shift_q;
                                link.stop_bit   <= vote;
                                state_q         <= AR_HUNT; // RQ17
                            end else begin
                                shift_q <= {vote, shift_q[7:1]}; // RQ18
                            end
                        end
                        if (slice_q == SLICE_LAST) begin
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= AR_HUNT;
                end
            endcase
        end
    end

endmodule

// ===== verilog/serial_port.sv
// serial port core: shift mode engine, async transmitter, registers
`timescale 1ns/1ns
module serial_port
    import serial_port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_write,
    input  wire logic       bus_read,
    output logic      [7:0] bus_rdata,
    output logic            irq,
    input  wire logic       data_pin_in,
    output logic            data_pin_out,
    output logic            data_pin_oe,
    output logic            clock_pin_out
);

    // ============================================================
    // state
    logic              data_meta_q;
    logic              data_sync_q;
    logic              async_mode_q;
    logic              rate_select_bit_q;
    logic              rx_en_q;
    logic              stop_bit_capture_q;
    logic              tx_done_flag_q;
    logic              rx_done_flag_q;
    logic [7:0]        tx_reg_q;
    logic [7:0]        serial_buffer_q;
    logic [7:0]        baud_div_q;
    logic [7:0]        baud_cnt_q;
    logic              tick16_q;
    logic [NUM_EV-1:0] status_q;
    logic [NUM_EV-1:0] irq_en_q;
    logic [7:0]        rdata_q;
    logic              irq_q;
    logic              data_out_q;
    logic              data_oe_q;
    logic              clock_pin_q;

    shift_state_e      sh_state_q;
    logic [3:0]        sh_phase_q;
    logic [2:0]        sh_bit_q;
    logic [7:0]        sh_data_q;

    async_tx_state_e   at_state_q;
    logic [9:0]        at_shift_q;
    logic [3:0]        at_slice_q;
    logic [3:0]        at_bit_q;

    // ============================================================
    // decode and events
    logic              wr_buffer;
    logic              wr_control;
    logic [3:0]        period;
    logic [3:0]        lead;
    logic [3:0]        low_end;
    logic              sh_bit_end;
    logic              sh_sample;
    logic              sclk_low;
    logic              shift_tx_end;
    logic              shift_rx_end;
    logic              async_tx_end;
    logic              async_load;
    logic              async_lost;
    logic [NUM_EV-1:0] events;

    rx_link_if rx_link ();

    assign wr_buffer  = bus_write && (bus_addr == ADDR_BUFFER);
    assign wr_control = bus_write && (bus_addr == ADDR_CONTROL);

    always_comb begin
        if (rate_select_bit_q) begin
            period = SHIFT_PERIOD_FAST; // RQ6
            lead   = SHIFT_LEAD_FAST; // RQ8
            low_end = SHIFT_LEAD_FAST + SHIFT_LOW_FAST; // RQ8
        end else begin
            period = SHIFT_PERIOD_SLOW; // RQ6
            lead   = SHIFT_LEAD_SLOW; // RQ9
            low_end = SHIFT_LEAD_SLOW + SHIFT_LOW_SLOW; // RQ9
        end
    end

    assign sh_bit_end = (sh_phase_q == period - 4'h1);
    assign sh_sample  = (sh_phase_q == low_end - 4'h1);
    assign sclk_low   = (sh_state_q != SH_IDLE) && (sh_phase_q >= lead)
                      && (sh_phase_q < low_end);
    assign shift_tx_end = (sh_state_q == SH_TX) && sh_bit_end
                        && (sh_bit_q == SHIFT_LAST_BIT);
    assign shift_rx_end = (sh_state_q == SH_RX) && sh_bit_end
                        && (sh_bit_q == SHIFT_LAST_BIT);
    assign async_tx_end = (at_state_q == AT_RUN) && tick16_q
                        && (at_slice_q == SLICE_LAST) && (at_bit_q == BIT_STOP);
    assign async_load = rx_link.frame_done && !rx_done_flag_q
                      && (!rate_select_bit_q || rx_link.stop_bit); // RQ15
    assign async_lost = rx_link.frame_done && !async_load;

    assign events[EV_TX_DONE] = shift_tx_end || async_tx_end;
    assign events[EV_RX_DONE] = shift_rx_end || async_load;
    assign events[EV_RX_LOST] = async_lost;

    // ============================================================
    // data pin synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_meta_q <= 1'b1;
            data_sync_q <= 1'b1;
        end else begin
            data_meta_q <= data_pin_in;
            data_sync_q <= data_meta_q;
        end
    end

    // ============================================================
    // control register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            async_mode_q      <= 1'b0;
            rate_select_bit_q <= 1'b0;
            rx_en_q           <= 1'b0;
        end else if (wr_control) begin
            async_mode_q      <= bus_wdata[CTL_ASYNC];
            rate_select_bit_q <= bus_wdata[CTL_RATE_SEL];
            rx_en_q           <= bus_wdata[CTL_RX_EN];
        end
    end

    // done flags: software may only clear; a same-cycle set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_done_flag_q <= 1'b0;
            rx_done_flag_q <= 1'b0;
        end else begin
            if (events[EV_TX_DONE]) begin
                tx_done_flag_q <= 1'b1;
            end else if (wr_control && !bus_wdata[CTL_TX_DONE]) begin
                tx_done_flag_q <= 1'b0;
            end
            if (events[EV_RX_DONE]) begin
                rx_done_flag_q <= 1'b1; // RQ16
            end else if (wr_control && !bus_wdata[CTL_RX_DONE]) begin
                rx_done_flag_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // transmit register and receive buffer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_reg_q <= BUFFER_RESET;
        end else if (wr_buffer) begin
            tx_reg_q <= bus_wdata; // RQ1
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_buffer_q    <= BUFFER_RESET;
            stop_bit_capture_q <= 1'b0;
        end else if (shift_rx_end) begin
            serial_buffer_q <= sh_data_q;
        end else if (async_load) begin
            serial_buffer_q    <= rx_link.data; // RQ16
            stop_bit_capture_q <= rx_link.stop_bit; // RQ16
        end
    end

    // ============================================================
    // 16x oversampling tick for asynchronous modes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            baud_div_q <= BAUD_DIV_RESET;
        end else if (bus_write && (bus_addr == ADDR_BAUD_DIV)) begin
            baud_div_q <= bus_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            baud_cnt_q <= 8'h00;
            tick16_q   <= 1'b0;
        end else if (baud_cnt_q >= baud_div_q) begin
            baud_cnt_q <= 8'h00;
            tick16_q   <= 1'b1;
        end else begin
            baud_cnt_q <= baud_cnt_q + 8'h01;
            tick16_q   <= 1'b0;
        end
    end

    // ============================================================
    // shift-mode engine; one engine for both directions
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_state_q <= SH_IDLE;
            sh_phase_q <= 4'h0;
            sh_bit_q   <= 3'h0;
            sh_data_q  <= 8'h00;
        end else begin
            case (sh_state_q)
                SH_IDLE: begin
                    sh_phase_q <= 4'h0;
                    sh_bit_q   <= 3'h0;
                    if (!async_mode_q && wr_buffer) begin
                        sh_state_q <= SH_TX; // RQ7
                        sh_data_q  <= bus_wdata;
                    end else if (!async_mode_q && rx_en_q
                                 && !rx_done_flag_q) begin
                        sh_state_q <= SH_RX; // RQ2
                    end
                end
                SH_TX, SH_RX: begin
                    sh_phase_q <= sh_bit_end ? 4'h0 : sh_phase_q + 4'h1;
                    if (sh_state_q == SH_RX && sh_sample) begin
                        // taken at the end of the low phase
                        sh_data_q <= {data_sync_q, sh_data_q[7:1]}; // RQ5
                    end
                    if (sh_bit_end) begin
                        sh_bit_q <= sh_bit_q + 3'h1;
                        if (sh_state_q == SH_TX) begin
                            sh_data_q <= {1'b1, sh_data_q[7:1]}; // RQ5
                        end
                        if (sh_bit_q == SHIFT_LAST_BIT) begin
                            sh_state_q <= SH_IDLE; // RQ7
                        end
                    end
                end
                default: begin
                    sh_state_q <= SH_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // asynchronous transmitter, independent of the receiver
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            at_state_q <= AT_IDLE;
            at_shift_q <= 10'h3FF;
            at_slice_q <= 4'h0;
            at_bit_q   <= 4'h0;
        end else begin
            case (at_state_q)
                AT_IDLE: begin
                    at_slice_q <= 4'h0;
                    at_bit_q   <= 4'h0;
                    if (async_mode_q && wr_buffer) begin
                        at_state_q <= AT_RUN; // RQ3
                        at_shift_q <= {1'b1, bus_wdata, 1'b0}; // RQ18
                    end
                end
                AT_RUN: begin
                    if (tick16_q) begin
                        at_slice_q <= at_slice_q + 4'h1;
                        if (at_slice_q == SLICE_LAST) begin
                            at_bit_q   <= at_bit_q + 4'h1;
                            at_shift_q <= {1'b1, at_shift_q[9:1]}; // RQ18
                            if (at_bit_q == BIT_STOP) begin
                                at_state_q <= AT_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    at_state_q <= AT_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // pins: both lag the engine by one cycle, so spacing holds
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_out_q  <= 1'b1;
            data_oe_q   <= 1'b0;
            clock_pin_q <= 1'b1;
        end else begin
            data_oe_q  <= (sh_state_q == SH_TX); // RQ4
            data_out_q <= (sh_state_q == SH_TX) ? sh_data_q[0] : 1'b1;
            if (async_mode_q) begin
                clock_pin_q <= (at_state_q == AT_RUN) ? at_shift_q[0] : 1'b1;
            end else begin
                clock_pin_q <= ~sclk_low; // RQ8 RQ9 RQ10
            end
        end
    end

    // ============================================================
    // asynchronous receiver
    assign rx_link.tick16 = tick16_q;
    assign rx_link.rxd    = data_sync_q;
    assign rx_link.enable = async_mode_q && rx_en_q; // RQ3

    async_receiver u_async_receiver (
        .clk     (clk),
        .sys_rst (sys_rst),
        .link    (rx_link.receiver)
    );

    // ============================================================
    // interrupt status, clear and enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= EV_RESET;
        end else if (bus_write && (bus_addr == ADDR_IRQ_CLEAR)) begin
            status_q <= (status_q & ~bus_wdata[NUM_EV-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_en_q <= EV_RESET;
        end else if (bus_write && (bus_addr == ADDR_IRQ_ENABLE)) begin
            irq_en_q <= bus_wdata[NUM_EV-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & irq_en_q);
        end
    end

    // ============================================================
    // read port: data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (bus_read) begin
            case (bus_addr)
                ADDR_BUFFER:     rdata_q <= serial_buffer_q; // RQ1
                ADDR_CONTROL:    rdata_q <= {2'b00, rx_done_flag_q,
                                             tx_done_flag_q,
                                             stop_bit_capture_q, rx_en_q,
                                             rate_select_bit_q,
                                             async_mode_q};
                ADDR_STATUS:     rdata_q <= {5'h00, status_q};
                ADDR_IRQ_ENABLE: rdata_q <= {5'h00, irq_en_q};
                ADDR_BAUD_DIV:   rdata_q <= baud_div_q;
                default:         rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign bus_rdata     = rdata_q;
    assign irq           = irq_q;
    assign data_pin_out  = data_out_q;
    assign data_pin_oe   = data_oe_q;
    assign clock_pin_out = clock_pin_q;

endmodule

// ===== tb/serial_port_sva.sv
// assertions on the serial port pins and register bus
`timescale 1ns/1ns
module serial_port_sva
    import serial_port_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_write,
    input wire logic       bus_read,
    input wire logic [7:0] bus_rdata,
    input wire logic       irq,
    input wire logic       data_pin_in,
    input wire logic       data_pin_out,
    input wire logic       data_pin_oe,
    input wire logic       clock_pin_out
);
    // ============================================================
    // falls of the shift clock within one transmit frame
    logic       sclk_q;
    logic [3:0] nfall_q;
    always_ff @(posedge clk) begin
        sclk_q <= clock_pin_out;
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !data_pin_oe) begin
            nfall_q <= 4'h0;
        end else if (sclk_q && !clock_pin_out) begin
            nfall_q <= nfall_q + 4'h1;
        end
    end
    // ============================================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_rdata_slot_only: assert property (!$past(bus_read) |-> bus_rdata == 8'h00)
        else $error("rdata outside slot");
    a_unmapped_reads_zero: assert property ($past(bus_read) &&
        $past(bus_addr) > ADDR_BAUD_DIV |-> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_idle_pin_high: assert property (!data_pin_oe |-> data_pin_out)
        else $error("idle pin low");
    a_start_after_write: assert property ($rose(data_pin_oe) |->
        $past(bus_write, 2) && $past(bus_addr, 2) == ADDR_BUFFER)
        else $error("transmit without write");
    a_clock_low_width: assert property ($fell(clock_pin_out) && data_pin_oe
        |-> (!clock_pin_out[*2] ##1 clock_pin_out)
        or (!clock_pin_out[*6] ##1 clock_pin_out))
        else $error("clock low time");
    a_data_steady_low: assert property (data_pin_oe && !clock_pin_out
        |-> $stable(data_pin_out))
        else $error("data moved in low");
    a_eight_bit_frame: assert property ($fell(data_pin_oe) |-> nfall_q == 4'h8)
        else $error("not eight clocks");
    a_irq_masked: assert property (bus_write && bus_addr == ADDR_IRQ_ENABLE &&
        bus_wdata == 8'h00 |-> ##2 !irq)
        else $error("irq while masked");
    cover property ($fell(data_pin_oe));
    cover property ($rose(irq));
    cover property ($past(bus_read) && bus_rdata != 8'h00);
endmodule
bind serial_port serial_port_sva serial_port_sva_i (.*);

// ===== tb/serial_device_model.sv
// far-end shift device with async loopback
`timescale 1ns/1ns
module serial_device_model (
    input  wire logic       rst,
    input  wire logic       tx_line,
    input  wire logic       pin_out,
    input  wire logic       pin_oe,
    input  wire logic       loop,
    input  wire logic [7:0] reply,
    output logic            pin_in,
    output logic      [7:0] heard
);
    logic [2:0] idx_q;
    // ============================================================
    // capture on rising shift clock, then next reply bit
    always @(posedge tx_line or posedge rst) begin
        if (rst) begin
            idx_q <= 3'h0;
            heard <= 8'h00;
        end else if (pin_oe) begin
            heard <= {pin_out, heard[7:1]};
        end else if (!loop) begin
            idx_q <= idx_q + 3'h1;
        end
    end
    // design drive wins; loop feeds frames back
    assign pin_in = pin_oe ? pin_out : (loop ? tx_line : reply[idx_q]);
endmodule

// ===== tb/test_serial_port.sv
// self-checking bench for the serial port
`timescale 1ns/1ns
module test_serial_port import serial_port_pkg::*;;
    logic        clk, sys_rst, bus_write, bus_read, irq, loop, rd_seen;
    logic        pin_in, pin_out, pin_oe, sclk;
    logic [2:0]  bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, reply, heard, b;
    logic [31:0] seed;
    logic [7:0]  exp_q[$];
    int          n_errors = 0;
    int          checked = 0;
    serial_port serial_port_i (.*, .data_pin_in(pin_in),
        .data_pin_out(pin_out), .data_pin_oe(pin_oe), .clock_pin_out(sclk));
    serial_device_model serial_device_model_i (.rst(sys_rst), .tx_line(sclk),
        .pin_out(pin_out), .pin_oe(pin_oe), .loop(loop), .reply(reply),
        .pin_in(pin_in), .heard(heard));
    // ============================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clk);
        bus_write <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        exp_q.push_back(exp);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clk);
        bus_read <= 1'b0;
    endtask
    task automatic wait_oe();
        int n = 0;
        while (pin_oe !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        while (pin_oe !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ============================================================
    // read data one cycle after strobe
    always @(posedge clk) begin
        rd_seen <= bus_read;
        if (rd_seen === 1'b1) begin
            chk(bus_rdata, exp_q.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        {bus_addr, bus_wdata, bus_write, bus_read, loop} = '0;
        reply = '0;
        sys_rst = 1'b1;
        seed = 32'h6A91D377;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(ADDR_BAUD_DIV, BAUD_DIV_RESET);
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, 8'h00);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00);
        for (int rs = 0; rs < 2; rs++) begin
            seed = lfsr(seed);
            b = seed[7:0];
            wr(ADDR_CONTROL, {6'h00, rs[0], 1'b0});
            wr(ADDR_IRQ_ENABLE, 8'h01);
            wr(ADDR_BUFFER, b);
            wait_oe();
            chk(heard, b);
            repeat (3) @(posedge clk);
            chk({7'h00, irq}, 8'h01);
            wr(ADDR_IRQ_CLEAR, 8'h01);
            repeat (2) @(posedge clk);
            chk({7'h00, irq}, 8'h00);
        end
        // shift receive: pin left to the far end
        seed = lfsr(seed);
        reply <= seed[7:0];
        wr(ADDR_CONTROL, 8'h06);
        repeat (60) @(posedge clk);
        rd(ADDR_BUFFER, reply);
        rd(ADDR_STATUS, 8'h02);
        chk({7'h00, irq}, 8'h00);
        wr(ADDR_CONTROL, 8'h00);
        // async loopback: send and receive at once
        b = ~seed[15:8];
        loop <= 1'b1;
        wr(ADDR_BAUD_DIV, 8'h00);
        wr(ADDR_IRQ_CLEAR, 8'h07);
        wr(ADDR_CONTROL, 8'h05);
        wr(ADDR_BUFFER, b);
        repeat (200) @(posedge clk);
        rd(ADDR_BUFFER, b);
        rd(ADDR_CONTROL, 8'h3D);
        wr(ADDR_BUFFER, ~b);
        repeat (200) @(posedge clk);
        rd(ADDR_BUFFER, b);
        rd(ADDR_STATUS, 8'h07);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
